// file: design/nig_pkg.sv
package nig_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_GUARD = 6'h15;
   localparam logic [5:0] IDX_MAIN_MASK = 6'h16;
   localparam logic [5:0] IDX_TF_MASK = 6'h17;
   localparam logic [5:0] IDX_ERR_MASK = 6'h18;
   localparam logic [5:0] IDX_PT_MASK = 6'h19;
   localparam logic [5:0] IDX_MAIN_STAT = 6'h1A;
   localparam logic [5:0] IDX_TF_STAT = 6'h1B;
   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Reset values
   localparam logic [7:0] GUARD_RST = 8'h33;
   localparam logic [7:0] MASK_RST = 8'h00;
   // Writable bits of each mask; unused bits stay zero
   localparam logic [7:0] MAIN_MASK_WR = 8'hFE;
   localparam logic [7:0] TF_MASK_WR = 8'hFF;
   localparam logic [7:0] ERR_MASK_WR = 8'hFE;
   localparam logic [7:0] PT_MASK_WR = 8'hFB;
   // Main status bit positions
   localparam int MAIN_OSC = 7;
   localparam int MAIN_WL = 6;
   localparam int MAIN_RXS = 5;
   localparam int MAIN_RXE = 4;
   localparam int MAIN_TXE = 3;
   localparam int MAIN_COL = 2;
   localparam int MAIN_REST = 1;
   // Timer and field status bit positions
   localparam int TF_DCT = 7;
   localparam int TF_NRE = 6;
   localparam int TF_GPE = 5;
   localparam int TF_EON = 4;
   localparam int TF_EOF = 3;
   localparam int TF_CAC = 2;
   localparam int TF_CAT = 1;
   localparam int TF_NFCT = 0;
   // FIFO level thresholds in bytes
   localparam logic [9:0] FIFO_RX_HI = 10'h12C;
   localparam logic [9:0] FIFO_TX_LO = 10'h0C8;
   // Guard timing: fixed base plus count times one step of 2048 carrier periods
   localparam int CLK_MHZ = 50;
   localparam int GUARD_BASE_NS = 75000;
   localparam int GUARD_STEP_NS = 151000;
   localparam int GUARD_BASE_CYC = (GUARD_BASE_NS * CLK_MHZ + 999) / 1000;
   localparam int GUARD_STEP_CYC = (GUARD_STEP_NS * CLK_MHZ + 999) / 1000;
   // Guard sequencer states
   typedef enum logic [1:0] {G_IDLE, G_BASE, G_STEP} nig_guard_t;
endpackage

// file: design/nig_irq_guard.sv
// Contract
// - Eight-bit guard count, step 2048 carrier periods
// - Guard time is 75 us plus count steps
// - Guard count resets to 0x33
// - Mask bit 1 blocks source; masks reset 0
// - Oscillator stable sets main bit 7
// - FIFO level flag: rx over 300, tx under 200
// - Main bits 5..2: rxs, rxe, txe, collision
// - Suppressed disturbance frame sets main bit 1
// - Direct command end sets timer bit 7
// - No-response timer bit 6, general timer bit 5
// - Field rise bit 4, field drop bit 3
// - Avoidance collision sets timer bit 2
// - Guard expiry after avoidance sets bit 1
// - Initiator bit rate recognised sets bit 0
// - Error mask bits for errors and wake-ups
// - Passive target mask bits as listed
// - Reading status returns flags then clears
`timescale 1ns/1ps
module nig_irq_guard #(
   parameter int STEP_CYC = nig_pkg::GUARD_STEP_CYC // Cycles per guard step
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [nig_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [nig_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [nig_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic osc_stable_i,
   input wire logic ext_field_i,
   input wire logic [9:0] fifo_count_i,
   input wire logic rx_active_i,
   input wire logic tx_active_i,
   input wire logic ev_rxs_i,
   input wire logic ev_rxe_i,
   input wire logic ev_txe_i,
   input wire logic ev_col_i,
   input wire logic ev_restart_i,
   input wire logic ev_dct_i,
   input wire logic ev_nre_i,
   input wire logic ev_gpe_i,
   input wire logic ev_cac_i,
   input wire logic ev_nfct_i,
   input wire logic guard_start_i,
   input wire logic guard_ca_i,
   input wire logic [7:0] err_pend_i,
   input wire logic [7:0] pt_pend_i,
   output logic irq_o,
   output logic guard_busy_o,
   output logic guard_done_o
);
   import nig_pkg::*;

   // True when the word index matches and the byte offset is zero
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   // Register file
   logic [7:0] field_on_guard_count_r; // Guard count in steps
   logic [7:0] main_mask_r; // Main source masks
   logic [7:0] tf_mask_r; // Timer and field masks
   logic [7:0] err_mask_r; // Error and wake-up masks
   logic [7:0] pt_mask_r; // Passive target masks
   logic [7:0] main_r; // Main status flags
   logic [7:0] tf_r; // Timer and field status flags
   logic [7:0] main_nxt;
   logic [7:0] tf_nxt;

   // Bus handshake
   logic wait_r; // Drives waitrequest
   logic [DATA_W-1:0] rdata_r; // Captured read word
   logic irq_r;

   // Synchronisers for the two pins from outside the clock domain
   logic osc_s1_r, osc_s2_r, osc_s3_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic wl_prev_r; // Last FIFO level condition

   // Guard sequencer
   nig_guard_t g_state_r;
   logic [15:0] g_cnt_r; // Cycles left in current phase
   logic [7:0] g_steps_r; // Steps still to run
   logic g_ca_r; // Started by collision avoidance
   logic g_done_r;
   logic g_busy_r; // Registered busy, so the output comes from a flip-flop

   // Handshake decode: request is taken at the edge where waitrequest is low
   wire req = avs_read_i | avs_write_i;
   wire fire = req & ~wait_r;
   wire wr_fire = avs_write_i & fire & avs_byteenable_i[0];
   wire rd_fire = avs_read_i & fire;
   wire [7:0] wdat = avs_writedata_i[7:0];

   // Read multiplexer; unmapped addresses read zero
   wire [7:0] rd_mux =
      hit(avs_address_i, IDX_GUARD) ? field_on_guard_count_r :
      hit(avs_address_i, IDX_MAIN_MASK) ? main_mask_r :
      hit(avs_address_i, IDX_TF_MASK) ? tf_mask_r :
      hit(avs_address_i, IDX_ERR_MASK) ? err_mask_r :
      hit(avs_address_i, IDX_PT_MASK) ? pt_mask_r :
      hit(avs_address_i, IDX_MAIN_STAT) ? main_r :
      hit(avs_address_i, IDX_TF_STAT) ? tf_r : 8'h00;

   // Clear only the bits that were actually returned, so events landing
   // between capture and the completing edge are kept
   wire clr_main = rd_fire & hit(avs_address_i, IDX_MAIN_STAT);
   wire clr_tf = rd_fire & hit(avs_address_i, IDX_TF_STAT);

   // FIFO level condition depends on direction
   wire wl_cond = (rx_active_i && (fifo_count_i > FIFO_RX_HI)) ||
      (tx_active_i && (fifo_count_i < FIFO_TX_LO));

   // Event set vectors; masks play no part here
   wire [7:0] main_set = {
      osc_s2_r & ~osc_s3_r,
      wl_cond & ~wl_prev_r,
      ev_rxs_i, ev_rxe_i, ev_txe_i, ev_col_i,
      ev_restart_i,
      1'b0}; // Bit 0 unused
   wire [7:0] tf_set = {
      ev_dct_i,
      ev_nre_i, ev_gpe_i,
      ext_s2_r & ~ext_s3_r, ext_s3_r & ~ext_s2_r,
      ev_cac_i,
      g_done_r & g_ca_r,
      ev_nfct_i};

   // Flag update per bit; a set in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign main_nxt[gi] = (main_r[gi] & ~(clr_main & rdata_r[gi])) | main_set[gi];
         assign tf_nxt[gi] = (tf_r[gi] & ~(clr_tf & rdata_r[gi])) | tf_set[gi];
      end
   endgenerate

   // Any pending flag not masked raises the interrupt
   wire irq_nxt = |(main_r & ~main_mask_r) | |(tf_r & ~tf_mask_r) |
      |(err_pend_i & ~err_mask_r) | |(pt_pend_i & ~pt_mask_r);

   // Bus slave: one wait cycle, then answer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         wait_r <= ~(req & wait_r);
         if (req & wait_r) begin
            rdata_r <= {24'h000000, rd_mux};
         end
      end
   end

   // Configuration registers; write lands at the completing edge
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         field_on_guard_count_r <= GUARD_RST;
         main_mask_r <= MASK_RST;
         tf_mask_r <= MASK_RST;
         err_mask_r <= MASK_RST;
         pt_mask_r <= MASK_RST;
      end else if (wr_fire) begin
         if (hit(avs_address_i, IDX_GUARD)) field_on_guard_count_r <= wdat;
         if (hit(avs_address_i, IDX_MAIN_MASK)) main_mask_r <= wdat & MAIN_MASK_WR;
         if (hit(avs_address_i, IDX_TF_MASK)) tf_mask_r <= wdat & TF_MASK_WR;
         if (hit(avs_address_i, IDX_ERR_MASK)) err_mask_r <= wdat & ERR_MASK_WR;
         if (hit(avs_address_i, IDX_PT_MASK)) pt_mask_r <= wdat & PT_MASK_WR;
      end
   end

   // Status flags, event edge trackers and interrupt
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_r <= 8'h00;
         tf_r <= 8'h00;
         wl_prev_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         main_r <= main_nxt;
         tf_r <= tf_nxt;
         wl_prev_r <= wl_cond;
         irq_r <= irq_nxt;
      end
   end

   // Pin synchronisers; the second and third stages feed the edge detectors
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_stable_i;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
         ext_s1_r <= ext_field_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // Guard sequencer: base phase, then one phase per count step.
   // A start while busy is ignored so a running guard is never cut short.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         g_state_r <= G_IDLE;
         g_cnt_r <= 16'h0000;
         g_steps_r <= 8'h00;
         g_ca_r <= 1'b0;
         g_busy_r <= 1'b0;
         g_done_r <= 1'b0;
      end else begin
         g_done_r <= 1'b0;
         case (g_state_r)
            G_IDLE: begin
               if (guard_start_i) begin
                  g_state_r <= G_BASE;
                  g_cnt_r <= 16'(GUARD_BASE_CYC - 1);
                  g_steps_r <= field_on_guard_count_r;
                  g_ca_r <= guard_ca_i;
                  g_busy_r <= 1'b1;
               end
            end
            G_BASE, G_STEP: begin
               if (g_cnt_r != 16'h0000) begin
                  g_cnt_r <= g_cnt_r - 16'h0001;
               end else if (g_steps_r != 8'h00) begin
                  g_state_r <= G_STEP;
                  g_cnt_r <= 16'(STEP_CYC - 1);
                  g_steps_r <= g_steps_r - 8'h01;
               end else begin
                  g_state_r <= G_IDLE;
                  g_done_r <= 1'b1;
                  g_busy_r <= 1'b0;
               end
            end
            default: begin
               g_state_r <= G_IDLE;
               g_busy_r <= 1'b0;
            end
         endcase
      end
   end

   assign avs_waitrequest_o = wait_r;
   assign avs_readdata_o = rdata_r;
   assign irq_o = irq_r;
   assign guard_done_o = g_done_r;
   assign guard_busy_o = g_busy_r;

   // Helper: cycles since guard start and the length expected
   logic [31:0] g_elapsed_r;
   logic [31:0] g_expect_r;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         g_elapsed_r <= 32'h0;
         g_expect_r <= 32'h0;
      end else if (g_state_r == G_IDLE && guard_start_i) begin
         g_elapsed_r <= 32'h1;
         g_expect_r <= 32'(GUARD_BASE_CYC + 1) + 32'(field_on_guard_count_r) * 32'(STEP_CYC);
      end else if (g_state_r != G_IDLE) begin
         g_elapsed_r <= g_elapsed_r + 32'h1;
      end
   end

   property p_guard_len;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(g_done_r) |-> (g_elapsed_r == g_expect_r);
   endproperty
   a_guard_len: assert property (p_guard_len) else $error("guard length wrong");

   property p_guard_wr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_fire && hit(avs_address_i, IDX_GUARD)) |=> (field_on_guard_count_r == $past(wdat));
   endproperty
   a_guard_wr: assert property (p_guard_wr) else $error("guard count not written");

   property p_irq_set;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (|(main_r & ~main_mask_r) || |(tf_r & ~tf_mask_r)) |=> irq_o;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq missing");

   property p_irq_clr;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !irq_nxt |=> !irq_o;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq stuck");

   property p_rd_clear;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (clr_main && main_set == 8'h00) |=> (main_r == ($past(main_r) & ~$past(rdata_r[7:0])));
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read clear wrong");

   property p_masked_latch;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ev_rxs_i && main_mask_r[MAIN_RXS]) |=> main_r[MAIN_RXS];
   endproperty
   a_masked_latch: assert property (p_masked_latch) else $error("masked event lost");

   property p_field_rise;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(ext_s2_r) |=> tf_r[TF_EON] ##1 (tf_r[TF_EON] || $past(clr_tf));
   endproperty
   a_field_rise: assert property (p_field_rise) else $error("field rise not flagged");

   property p_fifo_level;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wl_cond && !wl_prev_r) |=> main_r[MAIN_WL];
   endproperty
   a_fifo_level: assert property (p_fifo_level) else $error("fifo level not flagged");

   property p_cat;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (g_done_r && g_ca_r) |=> tf_r[TF_CAT];
   endproperty
   a_cat: assert property (p_cat) else $error("guard expiry not flagged");

   property p_mask_rfu;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      wr_fire |=> (main_mask_r[0] == 1'b0) && (pt_mask_r[2] == 1'b0) && (err_mask_r[0] == 1'b0);
   endproperty
   a_mask_rfu: assert property (p_mask_rfu) else $error("unused mask bit set");

   // Exactly one wait cycle, then the answer, then waitrequest back up
   property p_wait_ans;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (req && wait_r) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("bus answer wrong");

   // A start taken in idle shows busy on the next cycle
   property p_busy_start;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (g_state_r == G_IDLE && guard_start_i) |=> guard_busy_o;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("guard not busy");

   // Busy has dropped by the time the done pulse shows
   property p_busy_end;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(g_done_r) |-> !guard_busy_o;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("guard busy after done");

endmodule // nig_irq_guard

// file: tb/nig_host_model.sv
`timescale 1ns/1ps
// Host controller stand-in: one bus master that keeps the request up until waitrequest drops
module nig_host_model (
   input wire logic core_clk_i,
   input wire logic avs_waitrequest_i,
   input wire logic [31:0] avs_readdata_i,
   output logic [7:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [31:0] avs_writedata_o,
   output logic [3:0] avs_byteenable_o
);
   // Idle bus at time zero
   initial begin
      avs_address_o = 8'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0;
      avs_byteenable_o = 4'h0;
   end
   // One access; no wait count is assumed, only the bench watchdog ends a hang
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] q);
      @(posedge core_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= {24'h0, d};
      avs_byteenable_o <= be;
      avs_read_o <= !wr;
      avs_write_o <= wr;
      // Waitrequest is taken at each rising edge, before the slave updates it
      @(posedge core_clk_i);
      while (avs_waitrequest_i !== 1'b0) begin
         @(posedge core_clk_i);
      end
      // Read data stands at the same edge as the answer
      q = avs_readdata_i[7:0];
      // Release right after the edge where the answer was taken
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
   endtask
endmodule // nig_host_model

// file: tb/nfc_irq_mask_status_guard_tb_top.sv
`timescale 1ns/1ps
module nfc_irq_mask_status_guard_tb_top;
   import nig_pkg::*;
   localparam int STEP = 4; // Short guard step keeps the run brief
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr;
   logic rd_s, wr_s, osc = 1'b0, fld = 1'b0, rxa = 1'b0, txa = 1'b0, gs = 1'b0, gca = 1'b0;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic wait_s, irq, busy, done;
   logic [9:0] fifo = 10'h000;
   logic [9:0] ev = 10'h000; // Event pulses, rxs..restart then dct,nre,gpe,cac,nfct
   logic [7:0] errp = 8'h00, ptp = 8'h00;
   int error_cnt = 0;
   int checks_done = 0;
   int tfb [5] = '{7, 6, 5, 2, 0}; // Timer status bit for events 5..9
   always #10 clk = ~clk;
   nig_host_model nig_host_model_i (.core_clk_i(clk), .avs_waitrequest_i(wait_s),
      .avs_readdata_i(rdata), .avs_address_o(addr), .avs_read_o(rd_s), .avs_write_o(wr_s),
      .avs_writedata_o(wdata), .avs_byteenable_o(be));
   nig_irq_guard #(.STEP_CYC(STEP)) nig_irq_guard_i (.core_clk_i(clk), .rst_n_i(rst_n),
      .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
      .osc_stable_i(osc), .ext_field_i(fld), .fifo_count_i(fifo), .rx_active_i(rxa),
      .tx_active_i(txa), .ev_rxs_i(ev[0]), .ev_rxe_i(ev[1]), .ev_txe_i(ev[2]),
      .ev_col_i(ev[3]), .ev_restart_i(ev[4]), .ev_dct_i(ev[5]), .ev_nre_i(ev[6]),
      .ev_gpe_i(ev[7]), .ev_cac_i(ev[8]), .ev_nfct_i(ev[9]), .guard_start_i(gs),
      .guard_ca_i(gca), .err_pend_i(errp), .pt_pend_i(ptp), .irq_o(irq),
      .guard_busy_o(busy), .guard_done_o(done));
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      nig_host_model_i.xfer(1'b0, a, 8'h00, 4'hF, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] b = 4'hF);
      logic [7:0] q;
      nig_host_model_i.xfer(1'b1, a, d, b, q);
   endtask
   // Read a register and compare
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      rd(a, q);
      chk(q, exp);
   endtask
   // Irq looked at mid-cycle, never at a driving edge
   // One full edge first, so a mask written by the last access reaches irq
   task automatic probe(input logic exp);
      @(posedge clk);
      @(negedge clk);
      chk(irq, exp);
   endtask
   task automatic t_reset();
      rdc(8'h54, GUARD_RST);
      for (int a = 8'h58; a <= 8'h6C; a += 4) begin
         rdc(8'(a), 8'h00);
      end
   endtask
   // Writable bits only; disabled byte lane and misaligned address are refused
   task automatic t_masks();
      logic [7:0] wm [4] = '{MAIN_MASK_WR, TF_MASK_WR, ERR_MASK_WR, PT_MASK_WR};
      for (int i = 0; i < 4; i++) begin
         wr(8'(8'h58 + 4 * i), 8'hFF);
         rdc(8'(8'h58 + 4 * i), wm[i]);
         wr(8'(8'h58 + 4 * i), 8'h00, 4'hE);
         rdc(8'(8'h58 + 4 * i), wm[i]);
         wr(8'(8'h58 + 4 * i), 8'h00);
      end
      wr(8'h59, 8'hFF);
      rdc(8'h58, 8'h00);
      rdc(8'h59, 8'h00);
   endtask
   task automatic pulse(input int i);
      ev <= 10'(1) << i;
      @(posedge clk);
      ev <= 10'h000;
      @(posedge clk);
   endtask
   // Every pulsed event input: flag, irq, read-clear, irq drop; then one masked event
   task automatic t_events();
      for (int i = 0; i < 10; i++) begin
         pulse(i);
         probe(1'b1);
         if (i < 5) begin
            rdc(8'h68, 8'(1) << (5 - i));
            rdc(8'h68, 8'h00);
         end else begin
            rdc(8'h6C, 8'(1) << tfb[i - 5]);
            rdc(8'h6C, 8'h00);
         end
         probe(1'b0);
         @(posedge clk);
      end
      wr(8'h58, 8'h20);
      pulse(0);
      probe(1'b0);
      rdc(8'h68, 8'h20);
      wr(8'h58, 8'h00);
   endtask
   // Pins are asynchronous, so allow a few edges for the synchroniser
   task automatic t_pins();
      osc <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(8'h68, 8'h80);
      fld <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(8'h6C, 8'h10);
      fld <= 1'b0;
      repeat (6) @(posedge clk);
      rdc(8'h6C, 8'h08);
   endtask
   // Threshold itself must not trigger, one byte beyond must
   task automatic t_fifo();
      rxa <= 1'b1;
      fifo <= FIFO_RX_HI;
      repeat (4) @(posedge clk);
      rdc(8'h68, 8'h00);
      fifo <= FIFO_RX_HI + 10'h001;
      repeat (4) @(posedge clk);
      rdc(8'h68, 8'h40);
      rxa <= 1'b0;
      txa <= 1'b1;
      fifo <= FIFO_TX_LO;
      repeat (4) @(posedge clk);
      rdc(8'h68, 8'h00);
      fifo <= FIFO_TX_LO - 10'h001;
      repeat (4) @(posedge clk);
      rdc(8'h68, 8'h40);
      txa <= 1'b0;
   endtask
   // Error and passive target pending lines gated by their masks
   task automatic t_ext();
      errp <= 8'h80;
      repeat (3) @(posedge clk);
      probe(1'b1);
      wr(8'h60, 8'h80);
      probe(1'b0);
      errp <= 8'h00;
      ptp <= 8'h01;
      repeat (3) @(posedge clk);
      probe(1'b1);
      wr(8'h64, 8'h01);
      probe(1'b0);
      ptp <= 8'h00;
      wr(8'h60, 8'h00);
      wr(8'h64, 8'h00);
   endtask
   // Guard run after avoidance; length from base plus count steps
   task automatic t_guard(input logic [7:0] cnt);
      logic [7:0] q;
      int n;
      int exp;
      exp = GUARD_BASE_CYC + int'(cnt) * STEP + 1;
      rd(8'h6C, q);
      wr(8'h54, cnt);
      gs <= 1'b1;
      gca <= 1'b1;
      @(posedge clk);
      gs <= 1'b0;
      @(negedge clk);
      chk(busy, 1'b1);
      n = 1;
      while (done !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk(32'(n >= exp && n <= exp + 1), 32'h1);
      rdc(8'h6C, 8'h02);
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_masks();
      t_events();
      t_pins();
      t_fifo();
      t_ext();
      t_guard(8'h00);
      t_guard(8'd33);
      close_out();
   end
endmodule // nfc_irq_mask_status_guard_tb_top
